//--- core/lprc_params.svh
// Register offsets, field positions, reset values and timing figures of the lamp/pin/RAM bank.
`ifndef LPRC_PARAMS_SVH
`define LPRC_PARAMS_SVH
`define LPRC_IDX_MISC 7'h38
`define LPRC_IDX_LAMP_MASK 7'h39
`define LPRC_IDX_SETTLE 7'h3D
`define LPRC_IDX_PINMAP 7'h3E
`define LPRC_IDX_POWER 7'h60
`define LPRC_IDX_LAMP_CTL 7'h68
`define LPRC_IDX_RAM_SEL 7'h6A
`define LPRC_IDX_WIN_BASE 7'h00
`define LPRC_WIN_COUNT 32
`define LPRC_MASK_ALL_ON 5'h1F
`define LPRC_MISC_SKIP_BIT 2
`define LPRC_CTL_FORCE_BIT 7
`define LPRC_CTL_INDEX_HI 5
`define LPRC_CTL_INDEX_LO 4
`define LPRC_POWER_BIT 0
`define LPRC_PIN_IRQ_HI 6
`define LPRC_PIN_IRQ_LO 4
`define LPRC_PIN_INVERT_BIT 3
`define LPRC_PIN_AUX_HI 2
`define LPRC_PIN_AUX_LO 0
`define LPRC_RAM_BANK_BIT 7
`define LPRC_RAM_OFS_HI 4
`define LPRC_RAM_OFS_LO 0
`define LPRC_RESET_BYTE 8'h00
`define LPRC_RAM_CHANNEL_SWITCH_MATRIX_A 5'h0C
`define LPRC_RAM_ANALOG_SETUP_AB 5'h10
`define LPRC_RAM_ANALOG_SETUP_CD 5'h11
`define LPRC_RAM_OFFSET_TRIM_DAC 5'h12
`define LPRC_SETTLE_UNIT_US 1024
`define LPRC_CLK_MHZ 20
`define LPRC_SETTLE_UNIT_CYCLES (`LPRC_SETTLE_UNIT_US * `LPRC_CLK_MHZ)
`endif

//--- core/lprc_pkg.sv
// Types shared by the lamp/pin/RAM configuration bank.
package lprc_pkg;
  typedef enum logic [2:0] {
    LPRC_SRC_NATIVE = 3'h0,
    LPRC_SRC_MEAS_DONE = 3'h1,
    LPRC_SRC_MEAS_ACTIVE = 3'h2,
    LPRC_SRC_LAMP_ACTIVE = 3'h3
  } lprc_pin_src_t;
  typedef enum logic [0:0] {
    LPRC_TMR_IDLE = 1'b0,
    LPRC_TMR_COUNT = 1'b1
  } lprc_tmr_state_t;
endpackage

//--- core/lprc_settle_if.sv
// Handshake between the register bank and the lamp settling timer.
`timescale 1ns/1ns
interface lprc_settle_if;
  logic start;
  logic firstCycle;
  logic skip;
  logic [7:0] units;
  logic busy;
  logic done;
  modport ctrl (output start, output firstCycle, output skip, output units, input busy,
    input done);
  modport timer (input start, input firstCycle, input skip, input units, output busy,
    output done);
endinterface

//--- core/lprc_settle_timer.sv
// Lamp settling delay timer, counted in units of one settle step.
`timescale 1ns/1ns
`include "lprc_params.svh"
module lprc_settle_timer
  import lprc_pkg::*;
#(
  parameter int unsigned UNIT_CYCLES = `LPRC_SETTLE_UNIT_CYCLES
)
(
  input wire logic clk,
  input wire logic rstN,
  lprc_settle_if.timer tif
);
  localparam logic [15:0] UNIT_LAST = 16'(UNIT_CYCLES - 1);
  lprc_tmr_state_t state_r, state_nxt;
  logic [15:0] tick_r, tick_nxt;
  logic [7:0] left_r, left_nxt;
  logic done_r, done_nxt;

  always_comb
  begin
    state_nxt = state_r;
    tick_nxt = tick_r;
    left_nxt = left_r;
    done_nxt = 1'b0;
    case (state_r)
      LPRC_TMR_IDLE:
      begin
        if (tif.start)
        begin
          // Later cycles may skip settling; a zero delay also completes at once.
          if ((tif.skip && !tif.firstCycle) || (tif.units == 8'h00))
            done_nxt = 1'b1;
          else
          begin
            state_nxt = LPRC_TMR_COUNT;
            tick_nxt = 16'h0000;
            left_nxt = tif.units;
          end
        end
      end
      LPRC_TMR_COUNT:
      begin
        if (tick_r == UNIT_LAST)
        begin
          tick_nxt = 16'h0000;
          left_nxt = left_r - 8'h01;
          if (left_r == 8'h01)
          begin
            state_nxt = LPRC_TMR_IDLE;
            done_nxt = 1'b1;
          end
        end
        else
          tick_nxt = tick_r + 16'h0001;
      end
      default:
        state_nxt = LPRC_TMR_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      state_r <= LPRC_TMR_IDLE;
      tick_r <= 16'h0000;
      left_r <= 8'h00;
      done_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      tick_r <= tick_nxt;
      left_r <= left_nxt;
      done_r <= done_nxt;
    end
  end

  assign tif.busy = (state_r == LPRC_TMR_COUNT);
  assign tif.done = done_r;
endmodule // lprc_settle_timer

//--- core/lprc_config_regs.sv
// Lamp mask, settle delay, pin routing and configuration RAM window registers.
// Behaviour
// - Hold a five-bit lamp mask per cycle; 0x1F lights all lamps, others reserved.
// - Two-bit cycle index steers mask writes to cycle A, B, C or D.
// - Delay integration after lamp switch-on by settle value times 1024 microseconds.
// - With the skip bit set, omit settling between cycles A through D.
// - Three-bit selector routes interrupt, done, active or lamp onto the interrupt pin.
// - Polarity bit inverts the interrupt pin level for any selected source.
// - Three-bit selector routes aux output, done, active or lamp onto the aux pin.
// - Bank bit maps the configuration RAM; five-bit index sets the window start.
// - RAM 0x0C channel switch A, 0x10-0x11 analog setup, 0x12 offset trim.
// - Lamp force-on acts only with power on and clears when power clears.
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ns
`include "lprc_params.svh"
module lprc_config_regs
  import lprc_pkg::*;
#(
  parameter int unsigned SETTLE_UNIT_CYCLES = `LPRC_SETTLE_UNIT_CYCLES
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [8:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic irqSignal,
  input wire logic auxOut,
  input wire logic measDone,
  input wire logic measActive,
  input wire logic lampActive,
  input wire logic lampOnStart,
  input wire logic lampFirstCycle,
  output logic settleDone,
  output logic settleBusy,
  output logic irqOutPin,
  output logic auxOutPin,
  output logic lampForceOn,
  output logic [4:0] lampMaskA,
  output logic [4:0] lampMaskB,
  output logic [4:0] lampMaskC,
  output logic [4:0] lampMaskD,
  output logic [7:0] channelSwitchA,
  output logic [7:0] analogSetupAb,
  output logic [7:0] analogSetupCd,
  output logic [7:0] offsetTrimDac
);
  logic rstSync1_r, rstSync2_r;
  logic rstN;
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [4:0] mask_r [4];
  logic [4:0] mask_nxt [4];
  logic [7:0] settle_r, settle_nxt;
  logic [6:0] pinmap_r, pinmap_nxt;
  logic [7:0] ramSel_r, ramSel_nxt;
  logic [1:0] cycIdx_r, cycIdx_nxt;
  logic force_r, force_nxt;
  logic power_r, power_nxt;
  logic skip_r, skip_nxt;
  logic [7:0] ram_r [`LPRC_WIN_COUNT];
  logic [7:0] ram_nxt [`LPRC_WIN_COUNT];
  logic irq_r, irq_nxt;
  logic aux_r, aux_nxt;
  logic [6:0] idx;
  logic inWindow;
  logic [4:0] ramAddr;
  logic wrEn;
  lprc_settle_if settleIf ();

  // Reset is asserted at once but released only after two clean edges.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstSync1_r <= 1'b0;
      rstSync2_r <= 1'b0;
    end
    else
    begin
      rstSync1_r <= 1'b1;
      rstSync2_r <= rstSync1_r;
    end
  end
  assign rstN = rstSync2_r;

  assign idx = address[8:2];
  assign inWindow = ramSel_r[`LPRC_RAM_BANK_BIT] && (idx[6:5] == `LPRC_IDX_WIN_BASE >> 5);
  assign ramAddr = ramSel_r[`LPRC_RAM_OFS_HI:`LPRC_RAM_OFS_LO] + idx[4:0];
  // One wait state: the answer is ready the cycle after the request appears.
  assign waitrequest = (read || write) && !ack_r;
  assign wrEn = write && ack_r && byteenable[0];

  always_comb
  begin
    ack_nxt = (read || write) && !ack_r;
    rdata_nxt = rdata_r;
    mask_nxt = mask_r;
    settle_nxt = settle_r;
    pinmap_nxt = pinmap_r;
    ramSel_nxt = ramSel_r;
    cycIdx_nxt = cycIdx_r;
    force_nxt = force_r;
    power_nxt = power_r;
    skip_nxt = skip_r;
    ram_nxt = ram_r;
    if (read && !ack_r)
    begin
      rdata_nxt = 32'h00000000;
      if (inWindow)
        rdata_nxt[7:0] = ram_r[ramAddr];
      else
        case (idx)
          `LPRC_IDX_MISC: rdata_nxt[`LPRC_MISC_SKIP_BIT] = skip_r;
          `LPRC_IDX_LAMP_MASK: rdata_nxt[4:0] = mask_r[cycIdx_r];
          `LPRC_IDX_SETTLE: rdata_nxt[7:0] = settle_r;
          `LPRC_IDX_PINMAP: rdata_nxt[6:0] = pinmap_r;
          `LPRC_IDX_POWER: rdata_nxt[`LPRC_POWER_BIT] = power_r;
          `LPRC_IDX_LAMP_CTL:
          begin
            rdata_nxt[`LPRC_CTL_FORCE_BIT] = force_r;
            rdata_nxt[`LPRC_CTL_INDEX_HI:`LPRC_CTL_INDEX_LO] = cycIdx_r;
          end
          `LPRC_IDX_RAM_SEL: rdata_nxt[7:0] = ramSel_r;
          default: rdata_nxt = 32'h00000000;
        endcase
    end
    if (wrEn)
    begin
      if (inWindow)
        ram_nxt[ramAddr] = writedata[7:0];
      else
        case (idx)
          `LPRC_IDX_MISC: skip_nxt = writedata[`LPRC_MISC_SKIP_BIT];
          `LPRC_IDX_LAMP_MASK: mask_nxt[cycIdx_r] = writedata[4:0];
          `LPRC_IDX_SETTLE: settle_nxt = writedata[7:0];
          `LPRC_IDX_PINMAP: pinmap_nxt = writedata[6:0];
          `LPRC_IDX_POWER: power_nxt = writedata[`LPRC_POWER_BIT];
          `LPRC_IDX_LAMP_CTL:
          begin
            force_nxt = writedata[`LPRC_CTL_FORCE_BIT];
            cycIdx_nxt = writedata[`LPRC_CTL_INDEX_HI:`LPRC_CTL_INDEX_LO];
          end
          `LPRC_IDX_RAM_SEL:
          begin
            ramSel_nxt = writedata[7:0];
            ramSel_nxt[6:5] = 2'h0;
          end
          default: ramSel_nxt = ramSel_r;
        endcase
    end
    // Force-on cannot survive power-off, even if written in the same access.
    if (!power_nxt)
      force_nxt = 1'b0;
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      ack_r <= 1'b0;
      rdata_r <= 32'h00000000;
      mask_r <= '{default: 5'h00};
      settle_r <= `LPRC_RESET_BYTE;
      pinmap_r <= 7'h00;
      ramSel_r <= `LPRC_RESET_BYTE;
      cycIdx_r <= 2'h0;
      force_r <= 1'b0;
      power_r <= 1'b0;
      skip_r <= 1'b0;
      ram_r <= '{default: 8'h00};
    end
    else
    begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
      mask_r <= mask_nxt;
      settle_r <= settle_nxt;
      pinmap_r <= pinmap_nxt;
      ramSel_r <= ramSel_nxt;
      cycIdx_r <= cycIdx_nxt;
      force_r <= force_nxt;
      power_r <= power_nxt;
      skip_r <= skip_nxt;
      ram_r <= ram_nxt;
    end
  end

  // Reserved selector codes give a low source, so the pin rests at its idle level.
  always_comb
  begin
    case (lprc_pin_src_t'(pinmap_r[`LPRC_PIN_IRQ_HI:`LPRC_PIN_IRQ_LO]))
      LPRC_SRC_NATIVE: irq_nxt = irqSignal;
      LPRC_SRC_MEAS_DONE: irq_nxt = measDone;
      LPRC_SRC_MEAS_ACTIVE: irq_nxt = measActive;
      LPRC_SRC_LAMP_ACTIVE: irq_nxt = lampActive;
      default: irq_nxt = 1'b0;
    endcase
    irq_nxt = irq_nxt ^ pinmap_r[`LPRC_PIN_INVERT_BIT];
    case (lprc_pin_src_t'(pinmap_r[`LPRC_PIN_AUX_HI:`LPRC_PIN_AUX_LO]))
      LPRC_SRC_NATIVE: aux_nxt = auxOut;
      LPRC_SRC_MEAS_DONE: aux_nxt = measDone;
      LPRC_SRC_MEAS_ACTIVE: aux_nxt = measActive;
      LPRC_SRC_LAMP_ACTIVE: aux_nxt = lampActive;
      default: aux_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      irq_r <= 1'b0;
      aux_r <= 1'b0;
    end
    else
    begin
      irq_r <= irq_nxt;
      aux_r <= aux_nxt;
    end
  end

  assign settleIf.start = lampOnStart;
  assign settleIf.firstCycle = lampFirstCycle;
  assign settleIf.skip = skip_r;
  assign settleIf.units = settle_r;

  lprc_settle_timer #(
    .UNIT_CYCLES(SETTLE_UNIT_CYCLES)
  ) settleTimer (
    .clk(clk),
    .rstN(rstN),
    .tif(settleIf)
  );

  assign readdata = rdata_r;
  assign settleDone = settleIf.done;
  assign settleBusy = settleIf.busy;
  assign irqOutPin = irq_r;
  assign auxOutPin = aux_r;
  assign lampForceOn = force_r && power_r;
  assign lampMaskA = mask_r[0];
  assign lampMaskB = mask_r[1];
  assign lampMaskC = mask_r[2];
  assign lampMaskD = mask_r[3];
  assign channelSwitchA = ram_r[`LPRC_RAM_CHANNEL_SWITCH_MATRIX_A];
  assign analogSetupAb = ram_r[`LPRC_RAM_ANALOG_SETUP_AB];
  assign analogSetupCd = ram_r[`LPRC_RAM_ANALOG_SETUP_CD];
  assign offsetTrimDac = ram_r[`LPRC_RAM_OFFSET_TRIM_DAC];
endmodule // lprc_config_regs

//--- test/lprc_config_regs_assertions.sv
// Concurrent checks on bus answers, pin routing and the settle timer.
`timescale 1ns/1ns
module lprc_config_regs_assertions
#(
  parameter int unsigned SETTLE_UNIT_CYCLES = 4
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [8:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic irqSignal,
  input wire logic measDone,
  input wire logic measActive,
  input wire logic lampActive,
  input wire logic lampOnStart,
  input wire logic lampFirstCycle,
  input wire logic settleDone,
  input wire logic settleBusy,
  input wire logic irqOutPin
);
  logic [7:0] pinR, dlyR, miscR;
  logic [31:0] cntR;
  wire acc = write && !waitrequest;
  wire [3:0] src = {lampActive, measActive, measDone, irqSignal};
  wire irqExp = (pinR[6] ? 1'b0 : src[pinR[5:4]]) ^ pinR[3];
  // Shadows of the bank's registers let the checks name the programmed values.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinR <= 8'h00;
      dlyR <= 8'h00;
      miscR <= 8'h00;
      cntR <= 32'h0;
    end
    else
    begin
      if (acc && address[8:2] == 7'h3E)
        pinR <= writedata[7:0];
      if (acc && address[8:2] == 7'h3D)
        dlyR <= writedata[7:0];
      if (acc && address[8:2] == 7'h38)
        miscR <= writedata[7:0];
      cntR <= settleBusy ? cntR + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence sStart;
    lampOnStart && !settleBusy;
  endsequence
  a_bus_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");
  a_read_upper_zero: assert property (read && !waitrequest |-> readdata[31:8] == 24'h000000)
    else $error("read upper bits set");
  a_irq_route: assert property (irqOutPin == $past(irqExp))
    else $error("irq pin wrong");
  a_irq_reserved: assert property ($past(pinR[6]) |-> irqOutPin == $past(pinR[3]))
    else $error("irq pin not inactive");
  a_settle_zero: assert property (sStart ##0 dlyR == 8'h00 |=> settleDone && !settleBusy)
    else $error("zero delay not immediate");
  a_settle_skip: assert property (sStart ##0 (miscR[2] && !lampFirstCycle) |=> settleDone)
    else $error("skip not honoured");
  a_settle_start: assert property (sStart ##0 (dlyR != 8'h00 && (lampFirstCycle || !miscR[2]))
    |=> settleBusy && !settleDone)
    else $error("settle did not start");
  a_settle_length: assert property ($fell(settleBusy)
    |-> settleDone && cntR == dlyR * SETTLE_UNIT_CYCLES)
    else $error("settle length wrong");
  a_done_idle: assert property (settleDone |-> !settleBusy)
    else $error("done while busy");
endmodule // lprc_config_regs_assertions
bind lprc_config_regs lprc_config_regs_assertions
  #(.SETTLE_UNIT_CYCLES(SETTLE_UNIT_CYCLES)) chk (.clk, .rst_n, .address, .read, .write,
  .writedata, .readdata, .waitrequest, .irqSignal, .measDone, .measActive, .lampActive,
  .lampOnStart, .lampFirstCycle, .settleDone, .settleBusy, .irqOutPin);

//--- test/lprc_host_model.sv
// Avalon-MM host issuing single register accesses to the bank.
`timescale 1ns/1ns
module lprc_host_model
(
  input wire logic clk,
  output logic [8:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest
);
  logic hung = 1'b0;
  initial
  begin
    address = 9'h000;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
  end
  task automatic xfer(input logic rnw, input logic [6:0] idx, input logic [7:0] d,
    output logic [7:0] q);
    int n;
    @(posedge clk);
    address <= {idx, 2'b00};
    writedata <= {24'h000000, d};
    read <= rnw;
    write <= !rnw;
    n = 0;
    // Request stays put until waitrequest is seen low at an edge.
    do
    begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 64);
    hung = hung | (n >= 64);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask
endmodule // lprc_host_model

//--- test/lprc_config_regs_bench.sv
// Self-checking bench for the lamp, pin routing and RAM window registers.
`timescale 1ns/1ns
module lprc_config_regs_bench;
  logic clk, rst_n, irqSignal, auxOut, measDone, measActive, lampActive;
  logic lampOnStart, lampFirstCycle, read, write, waitrequest, settleDone, settleBusy;
  logic irqOutPin, auxOutPin, lampForceOn, e;
  logic [8:0] address;
  logic [31:0] writedata, readdata;
  logic [4:0] lampMaskA, lampMaskB, lampMaskC, lampMaskD;
  logic [7:0] channelSwitchA, analogSetupAb, analogSetupCd, offsetTrimDac, q;
  logic [3:0] v;
  int fail_count = 0;
  int n_tests = 0;
  lprc_config_regs #(.SETTLE_UNIT_CYCLES(4)) uut (.clk, .rst_n, .address, .read, .write,
    .byteenable(4'hF), .writedata, .readdata, .waitrequest, .irqSignal, .auxOut, .measDone,
    .measActive, .lampActive, .lampOnStart, .lampFirstCycle, .settleDone, .settleBusy,
    .irqOutPin, .auxOutPin, .lampForceOn, .lampMaskA, .lampMaskB, .lampMaskC, .lampMaskD,
    .channelSwitchA, .analogSetupAb, .analogSetupCd, .offsetTrimDac);
  lprc_host_model host (.clk, .address, .read, .write, .writedata, .readdata, .waitrequest);
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    host.xfer(1'b0, i, d, q);
    if (host.hung)
      report_and_stop;
    #1;
  endtask
  task automatic rd(input logic [6:0] i, input logic [7:0] x, input string n);
    host.xfer(1'b1, i, 8'h00, q);
    if (host.hung)
      report_and_stop;
    chk(n, {24'h0, x}, {24'h0, q});
  endtask
  task automatic pulse(input logic first, input int x);
    int n;
    @(posedge clk);
    lampFirstCycle <= first;
    lampOnStart <= 1'b1;
    @(posedge clk);
    lampOnStart <= 1'b0;
    // The start edge itself is the first edge counted, so an immediate answer is seen here.
    n = 1;
    #1;
    while (settleDone !== 1'b1 && n < 1100)
    begin
      @(posedge clk);
      n++;
      #1;
    end
    chk("settle", 32'(x), 32'(n));
    if (n >= 1100)
      report_and_stop;
  endtask
  task automatic t_masks;
    rd(7'h05, 8'h00, "unmapped");
    rd(7'h6A, 8'h00, "ram sel");
    for (int i = 0; i < 4; i++)
    begin
      wr(7'h68, {2'b00, i[1:0], 4'h0});
      wr(7'h39, 8'h1F - 8'(i));
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(7'h68, {2'b00, i[1:0], 4'h0});
      rd(7'h39, 8'h1F - 8'(i), "mask");
    end
    chk("masks", 32'h000E77DF, {12'h0, lampMaskD, lampMaskC, lampMaskB, lampMaskA});
    $display("masks end");
  endtask
  task automatic t_pins;
    for (int c = 0; c < 8; c++)
      for (int k = 0; k < 2; k++)
      begin
        wr(7'h3E, {1'b0, c[2:0], k[0], c[2:0]});
        for (int p = 0; p < 16; p++)
        begin
          v = p[3:0];
          @(posedge clk);
          {lampActive, measActive, measDone, irqSignal} <= v;
          auxOut <= ~v[0];
          repeat (2) @(posedge clk);
          #1;
          e = (c < 4) ? v[c[1:0]] : 1'b0;
          chk("irq pin", {31'h0, e ^ k[0]}, {31'h0, irqOutPin});
          e = (c == 0) ? ~v[0] : e;
          chk("aux pin", {31'h0, e}, {31'h0, auxOutPin});
        end
      end
    $display("pins end");
  endtask
  task automatic t_ram;
    wr(7'h6A, 8'h8C);
    rd(7'h6A, 8'h8C, "ram sel");
    for (int k = 0; k < 7; k++)
      wr(7'(k), 8'hA0 + 8'(k));
    chk("ram", 32'hA0A4A5A6, {channelSwitchA, analogSetupAb, analogSetupCd, offsetTrimDac});
    wr(7'h6A, 8'h90);
    rd(7'h02, 8'hA6, "window");
    rd(7'h1F, 8'hA3, "wrap");
    wr(7'h6A, 8'h10);
    rd(7'h02, 8'h00, "bank off");
    $display("ram end");
  endtask
  task automatic t_settle;
    wr(7'h3D, 8'h02);
    pulse(1'b1, 9);
    wr(7'h38, 8'h04);
    pulse(1'b0, 1);
    pulse(1'b1, 9);
    wr(7'h38, 8'h00);
    pulse(1'b0, 9);
    wr(7'h3D, 8'hFF);
    pulse(1'b1, 1021);
    wr(7'h3D, 8'h00);
    pulse(1'b1, 1);
    $display("settle end");
  endtask
  task automatic t_force;
    wr(7'h68, 8'h80);
    rd(7'h68, 8'h00, "force");
    wr(7'h60, 8'h01);
    wr(7'h68, 8'h80);
    chk("force on", 32'h1, {31'h0, lampForceOn});
    wr(7'h60, 8'h00);
    chk("force off", 32'h0, {31'h0, lampForceOn});
    rd(7'h68, 8'h00, "force");
    $display("force end");
  endtask
  task automatic report_and_stop;
    fail_count += int'(host.hung);
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    rst_n = 1'b0;
    {irqSignal, auxOut, measDone, measActive, lampActive} = 5'h00;
    lampOnStart = 1'b0;
    lampFirstCycle = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_masks;
    t_pins;
    t_ram;
    t_settle;
    t_force;
    report_and_stop;
  end
endmodule // lprc_config_regs_bench
